// ===== core/eci_top.sv
`timescale 1ns/10ps
`include "eci_consts.svh"

// Notes on behaviour
// - Delivery needs the line armed and enabled
// - Reset leaves all lines disarmed, disabled
// - Armed line: recognised request sets request bit
// - Disarm clears request and ignores new ones
// - Enabled requests enter priority resolution
// - Disabled armed line holds request until enabled
// - No new delivery until pending cleared
// - Delivery goes to host only; chain gets the raw routed input
// - Default recognition is an input edge
// - Edge needs inactive then active again
// - Level mode requests while level holds
// - Software request stays local, chain untouched
// - Routed input drives chained line directly
// - Local and chained source get separate vectors
// - Chained lines start disarmed
// - Twelve external input lines, zero to eleven
// - Per-input rise/fall/high/low, falling default
module eci_top
    import eci_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    input  wire eci_axi_req_t            axiReq,
    output eci_axi_rsp_t                 axiRsp,
    input  wire logic [`ECI_NUM_EXT-1:0] extIn,
    input  wire logic [`ECI_NUM_CH-1:0]  chainIn,
    output logic      [`ECI_NUM_CH-1:0]  chainOut,
    output logic      [`ECI_NUM_CH-1:0]  chainOe,
    output logic                         hostIrq,
    output logic      [`ECI_IDX_W-1:0]   hostVector
);

    localparam int NL = `ECI_NUM_LINES;
    localparam int NE = `ECI_NUM_EXT;
    localparam int NC = `ECI_NUM_CH;
    localparam int CL = `ECI_CH_LSB;
    localparam int RW = `ECI_ROUTE_W;

    // Register address to selection
    function automatic eci_reg_t decodeReg(input logic [`ECI_ADDR_W-1:0] a);
        if (a == `ECI_OFF_EXT_ARM) return ECI_RG_EXT_ARM;
        else if (a == `ECI_OFF_EXT_EN) return ECI_RG_EXT_EN;
        else if (a == `ECI_OFF_EXT_REQ) return ECI_RG_EXT_REQ;
        else if (a == `ECI_OFF_EXT_PEND) return ECI_RG_EXT_PEND;
        else if (a == `ECI_OFF_EXT_MODE) return ECI_RG_EXT_MODE;
        else if (a == `ECI_OFF_ROUTE) return ECI_RG_ROUTE;
        else if (a == `ECI_OFF_CH_ARM) return ECI_RG_CH_ARM;
        else if (a == `ECI_OFF_CH_EN) return ECI_RG_CH_EN;
        else if (a == `ECI_OFF_CH_REQ) return ECI_RG_CH_REQ;
        else if (a == `ECI_OFF_CH_PEND) return ECI_RG_CH_PEND;
        else if (a == `ECI_OFF_VECTOR) return ECI_RG_VECTOR;
        else return ECI_RG_NONE;
    endfunction

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[b*8 +: 8] = nw[b*8 +: 8];
        end
        return res;
    endfunction

    // Line state, externals low, chained lines high
    logic [NL-1:0]   lineArm;
    logic [NL-1:0]   lineEn;
    logic [NL-1:0]   lineReq;
    logic [NL-1:0]   linePend;
    logic [2*NE-1:0] extMode;
    logic [31:0]     route;

    logic [NL-1:0]   next_lineArm;
    logic [NL-1:0]   next_lineEn;
    logic [NL-1:0]   next_lineReq;
    logic [NL-1:0]   next_linePend;
    logic [2*NE-1:0] next_extMode;
    logic [31:0]     next_route;
    logic [NC-1:0]   next_chainOut;
    logic [NC-1:0]   next_chainOe;
    eci_axi_rsp_t    next_rsp;

    logic [NL-1:0]         hit;
    logic [NL-1:0]         swReq;
    logic [NL-1:0]         clrPend;
    logic [NL-1:0]         cand;
    logic [NL-1:0]         delivVec;
    logic [`ECI_IDX_W-1:0] prioIdx;
    logic                  prioFound;
    logic [31:0]           rdValue;

    // Recognition for every line; chained lines use rising edge
    genvar gi;
    generate
        for (gi = 0; gi < NL; gi++) begin : g_line
            if (gi < NE) begin : g_ext
                eci_recog u_recog (
                    .ref_clk (ref_clk),
                    .nrst    (nrst),
                    .sigIn   (extIn[gi]),
                    .mode    (eci_mode_t'(extMode[2*gi +: 2])),
                    .hit     (hit[gi])
                );
            end else begin : g_ch
                eci_recog u_recog (
                    .ref_clk (ref_clk),
                    .nrst    (nrst),
                    .sigIn   (chainIn[gi-NE]),
                    .mode    (ECI_RISE),
                    .hit     (hit[gi])
                );
            end
        end
    endgenerate

    // Bus handshakes and decoded targets
    wire      wrFire = axiRsp.awready;
    wire      rdFire = axiRsp.arready;
    eci_reg_t wrSel;
    eci_reg_t rdSel;
    assign wrSel = decodeReg(axiReq.awaddr);
    assign rdSel = decodeReg(axiReq.araddr);
    wire [31:0] wOnes = mergeStrb(32'h0000_0000, axiReq.wdata, axiReq.wstrb);
    // Byte lanes that a write touches; untouched lanes keep their bits
    wire [31:0] wMask = mergeStrb(32'h0000_0000, 32'hFFFF_FFFF, axiReq.wstrb);

    // Write one to request or to clear pending
    assign swReq[NE-1:0] = (wrFire && wrSel == ECI_RG_EXT_REQ) ? wOnes[NE-1:0] : '0;
    assign swReq[NL-1:CL] = (wrFire && wrSel == ECI_RG_CH_REQ) ? wOnes[NC-1:0] : '0;
    assign clrPend[NE-1:0] = (wrFire && wrSel == ECI_RG_EXT_PEND) ? wOnes[NE-1:0] : '0;
    assign clrPend[NL-1:CL] = (wrFire && wrSel == ECI_RG_CH_PEND) ? wOnes[NC-1:0] : '0;

    // Candidates: enabled lines with a request not yet pending
    assign cand = lineEn & lineReq & ~linePend;

    eci_prio u_prio (
        .cand  (cand),
        .idx   (prioIdx),
        .found (prioFound)
    );

    // One interrupt out at a time keeps the vector unambiguous
    assign delivVec = (prioFound && linePend == '0) ?
                      (NL'(1) << prioIdx) : '0;

    // Configuration writes honour byte strobes
    always_comb begin
        next_lineArm = lineArm;
        next_lineEn  = lineEn;
        next_extMode = extMode;
        next_route   = route;
        if (wrFire) begin
            if (wrSel == ECI_RG_EXT_ARM)
                next_lineArm[NE-1:0] = (lineArm[NE-1:0] & ~wMask[NE-1:0]) | wOnes[NE-1:0];
            else if (wrSel == ECI_RG_EXT_EN)
                next_lineEn[NE-1:0] = (lineEn[NE-1:0] & ~wMask[NE-1:0]) | wOnes[NE-1:0];
            else if (wrSel == ECI_RG_EXT_MODE)
                next_extMode = (extMode & ~wMask[2*NE-1:0]) | wOnes[2*NE-1:0];
            else if (wrSel == ECI_RG_ROUTE)
                next_route = (route & ~wMask) | wOnes;
            else if (wrSel == ECI_RG_CH_ARM)
                next_lineArm[NL-1:CL] = (lineArm[NL-1:CL] & ~wMask[NC-1:0]) | wOnes[NC-1:0];
            else if (wrSel == ECI_RG_CH_EN)
                next_lineEn[NL-1:CL] = (lineEn[NL-1:CL] & ~wMask[NC-1:0]) | wOnes[NC-1:0];
        end
    end

    // New requests win over the delivery clear; disarm wipes all
    assign next_lineReq = ((lineReq & ~delivVec) | ((hit | swReq) & lineArm))
                          & next_lineArm;
    // Delivery sets pending; a set beats a same-cycle clear
    assign next_linePend = (linePend & ~clrPend) | delivVec;

    // Raw input straight to its chained line, no local gating
    generate
        for (gi = 0; gi < NC; gi++) begin : g_route
            wire [RW-1:0] src = route[RW*gi +: RW];
            assign next_chainOe[gi] = (src < RW'(NE));
            assign next_chainOut[gi] = (src < RW'(NE)) ? extIn[src] : 1'b0;
        end
    endgenerate

    // Read data selection
    always_comb begin
        case (rdSel)
            ECI_RG_EXT_ARM:  rdValue = 32'(lineArm[NE-1:0]);
            ECI_RG_EXT_EN:   rdValue = 32'(lineEn[NE-1:0]);
            ECI_RG_EXT_REQ:  rdValue = 32'(lineReq[NE-1:0]);
            ECI_RG_EXT_PEND: rdValue = 32'(linePend[NE-1:0]);
            ECI_RG_EXT_MODE: rdValue = 32'(extMode);
            ECI_RG_ROUTE:    rdValue = route;
            ECI_RG_CH_ARM:   rdValue = 32'(lineArm[NL-1:CL]);
            ECI_RG_CH_EN:    rdValue = 32'(lineEn[NL-1:CL]);
            ECI_RG_CH_REQ:   rdValue = 32'(lineReq[NL-1:CL]);
            ECI_RG_CH_PEND:  rdValue = 32'(linePend[NL-1:CL]);
            ECI_RG_VECTOR:   rdValue = 32'({hostIrq, hostVector});
            default:         rdValue = 32'h0000_0000;
        endcase
    end

    // Slave waits for address and data together, then answers
    always_comb begin
        next_rsp = axiRsp;
        next_rsp.awready = axiReq.awvalid && axiReq.wvalid &&
                           !axiRsp.awready && !axiRsp.bvalid;
        next_rsp.wready = next_rsp.awready;
        next_rsp.arready = axiReq.arvalid && !axiRsp.arready && !axiRsp.rvalid;
        if (wrFire) begin
            next_rsp.bvalid = 1'b1;
            next_rsp.bresp = (wrSel == ECI_RG_NONE) ? `ECI_RESP_SLVERR : `ECI_RESP_OKAY;
        end else if (axiRsp.bvalid && axiReq.bready) begin
            next_rsp.bvalid = 1'b0;
        end
        if (rdFire) begin
            next_rsp.rvalid = 1'b1;
            next_rsp.rdata = rdValue;
            next_rsp.rresp = (rdSel == ECI_RG_NONE) ? `ECI_RESP_SLVERR : `ECI_RESP_OKAY;
        end else if (axiRsp.rvalid && axiReq.rready) begin
            next_rsp.rvalid = 1'b0;
        end
    end

    // Line state; all disarmed and disabled after reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lineArm  <= '0;
            lineEn   <= '0;
            lineReq  <= '0;
            linePend <= '0;
            extMode  <= `ECI_MODE_RST;
            route    <= `ECI_ROUTE_RST;
        end else begin
            lineArm  <= next_lineArm;
            lineEn   <= next_lineEn;
            lineReq  <= next_lineReq;
            linePend <= next_linePend;
            extMode  <= next_extMode;
            route    <= next_route;
        end
    end

    // Outputs, all from flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            axiRsp     <= '0;
            chainOut   <= '0;
            chainOe    <= '0;
            hostIrq    <= 1'b0;
            hostVector <= '0;
        end else begin
            axiRsp     <= next_rsp;
            chainOut   <= next_chainOut;
            chainOe    <= next_chainOe;
            hostIrq    <= |next_linePend;
            if (|delivVec) hostVector <= prioIdx;
        end
    end

    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    wire [NL-1:0] heldReq = lineReq & ~lineEn;

    sequence s_pend_clear;
        linePend != '0 ##1 linePend == '0;
    endsequence

    sequence s_routed0;
        route[RW-1:0] < RW'(NE);
    endsequence

    a_req_needs_arm: assert property ((lineReq & ~lineArm) == '0)
        else $error("request held on a disarmed line");

    a_deliv_gated: assert property (
        |delivVec |-> ((delivVec & ~(lineEn & lineArm)) == '0))
        else $error("delivery from a line not armed and enabled");

    a_one_pending: assert property ($onehot0(linePend))
        else $error("more than one line pending");

    a_no_redeliver: assert property (
        linePend != '0 |-> delivVec == '0)
        else $error("delivery while a pending bit stands");

    a_prio_lowest: assert property (
        |delivVec |-> ((cand & (delivVec - NL'(1))) == '0))
        else $error("lower line skipped by priority");

    a_disabled_holds: assert property (
        ##1 (($past(heldReq) & lineArm & ~lineReq) == '0))
        else $error("disabled line lost its request");

    a_clear_redeliver: assert property (
        (s_pend_clear ##0 cand != '0) |-> |delivVec)
        else $error("no delivery after pending clear");

    a_irq_vector: assert property (
        hostIrq |-> (hostIrq == |linePend) && linePend[hostVector])
        else $error("host vector does not name the pending line");

    a_chain_direct: assert property (
        s_routed0 |=> chainOe[0] && chainOut[0] == $past(extIn[route[RW-1:0]]))
        else $error("routed input not on its chained line");

    a_sw_local: assert property (
        ($stable(extIn) && $stable(route)) |=> $stable(chainOut))
        else $error("chained line moved without an input change");

    // Delivery path to the host, one step at a time
    sequence s_deliver;
        delivVec != '0;
    endsequence

    a_deliv_irq: assert property (
        s_deliver |=> hostIrq && hostVector == $past(prioIdx))
        else $error("delivery did not reach the host");

    a_vector_held: assert property (
        hostIrq |=> $stable(hostVector))
        else $error("host vector moved while a line was pending");

    a_req_sets: assert property (
        ##1 (($past((hit | swReq) & lineArm & next_lineArm) & ~lineReq) == '0))
        else $error("recognised request on an armed line was lost");

    a_pend_clears: assert property (
        (linePend & clrPend) != '0 |=> (($past(clrPend) & linePend) == '0))
        else $error("pending bit not cleared by the host");

    a_chain_off: assert property (
        route[RW-1:0] >= RW'(NE) |=> !chainOe[0])
        else $error("chained line driven with no source routed");

endmodule

// ===== core/eci_consts.svh
`ifndef ECI_CONSTS_SVH
`define ECI_CONSTS_SVH

// Line counts
`define ECI_NUM_EXT    12
`define ECI_NUM_CH     8
`define ECI_NUM_LINES  20
`define ECI_IDX_W      5
`define ECI_ADDR_W     8

// Register byte offsets
`define ECI_OFF_EXT_ARM  8'h00
`define ECI_OFF_EXT_EN   8'h04
`define ECI_OFF_EXT_REQ  8'h08
`define ECI_OFF_EXT_PEND 8'h0C
`define ECI_OFF_EXT_MODE 8'h10
`define ECI_OFF_ROUTE    8'h14
`define ECI_OFF_CH_ARM   8'h18
`define ECI_OFF_CH_EN    8'h1C
`define ECI_OFF_CH_REQ   8'h20
`define ECI_OFF_CH_PEND  8'h24
`define ECI_OFF_VECTOR   8'h28

// Field positions
`define ECI_CH_LSB     12
`define ECI_ROUTE_W    4
`define ECI_VEC_VALID  5

// Reset values: every input falling edge, no chained route
`define ECI_MODE_RST   24'h55_5555
`define ECI_ROUTE_RST  32'hFFFF_FFFF

// Bus responses
`define ECI_RESP_OKAY   2'h0
`define ECI_RESP_SLVERR 2'h2

// Least stable time of an input, for the far side
`define ECI_CLK_NS     40
`define ECI_HOLD_NS    1500
`define ECI_HOLD_CYC   ((`ECI_HOLD_NS + `ECI_CLK_NS - 1) / `ECI_CLK_NS)

`endif

// ===== core/eci_pkg.sv
`include "eci_consts.svh"

package eci_pkg;

    // Recognition mode of one line
    typedef enum logic [1:0] {
        ECI_RISE,
        ECI_FALL,
        ECI_HIGH,
        ECI_LOW
    } eci_mode_t;

    // Decoded register selection
    typedef enum logic [3:0] {
        ECI_RG_EXT_ARM, ECI_RG_EXT_EN, ECI_RG_EXT_REQ, ECI_RG_EXT_PEND,
        ECI_RG_EXT_MODE, ECI_RG_ROUTE, ECI_RG_CH_ARM, ECI_RG_CH_EN,
        ECI_RG_CH_REQ, ECI_RG_CH_PEND, ECI_RG_VECTOR, ECI_RG_NONE
    } eci_reg_t;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic                   awvalid;
        logic [`ECI_ADDR_W-1:0] awaddr;
        logic                   wvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bready;
        logic                   arvalid;
        logic [`ECI_ADDR_W-1:0] araddr;
        logic                   rready;
    } eci_axi_req_t;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } eci_axi_rsp_t;

endpackage

// ===== core/eci_recog.sv
`timescale 1ns/10ps
`include "eci_consts.svh"

module eci_recog
    import eci_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      nrst,
    input  wire logic      sigIn,
    input  wire eci_mode_t mode,
    output logic           hit
);

    logic prevSig;

    // Last sample, for edge detection
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prevSig <= 1'b0;
        end else begin
            prevSig <= sigIn;
        end
    end

    // Edge fires once per transition; level fires every cycle
    always_comb begin
        case (mode)
            ECI_RISE: hit = sigIn & ~prevSig;
            ECI_FALL: hit = ~sigIn & prevSig;
            ECI_HIGH: hit = sigIn;
            default:  hit = ~sigIn;
        endcase
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // One edge gives one request only
    a_edge_once: assert property (
        (hit && (mode == ECI_RISE || mode == ECI_FALL) ##1 $stable(mode)) |-> !hit)
        else $error("edge mode raised two requests in a row");

endmodule

// ===== core/eci_prio.sv
`timescale 1ns/10ps
`include "eci_consts.svh"

module eci_prio (
    input  wire logic [`ECI_NUM_LINES-1:0] cand,
    output logic      [`ECI_IDX_W-1:0]     idx,
    output logic                           found
);

    // Downward scan so the lowest set line wins
    always_comb begin
        idx   = '0;
        found = 1'b0;
        for (int i = `ECI_NUM_LINES - 1; i >= 0; i--) begin
            if (cand[i]) begin
                idx   = i[`ECI_IDX_W-1:0];
                found = 1'b1;
            end
        end
    end

endmodule

// ===== sim/eci_peer.sv
`timescale 1ns/10ps
`include "eci_consts.svh"

// Far side of the chain: peer boards and the wire between them
module eci_peer (
    input  wire logic [`ECI_NUM_CH-1:0] chainOut,
    input  wire logic [`ECI_NUM_CH-1:0] chainOe,
    input  wire logic [`ECI_NUM_CH-1:0] peerDrive,
    output logic      [`ECI_NUM_CH-1:0] chainIn
);
    // Wired-or with pull-down, so a released line reads low
    // Own drive shows on the line only while enabled
    assign chainIn = (chainOe & chainOut) | peerDrive;
endmodule

// ===== sim/eci_tb.sv
`timescale 1ns/10ps
`include "eci_consts.svh"
`define CHK(n, e, a) begin nChecks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end

module external_and_chained_interrupt_control_tb
    import eci_pkg::*;
();
    logic                    ref_clk;
    logic                    nrst;
    eci_axi_req_t            axiReq;
    eci_axi_rsp_t            axiRsp;
    logic [`ECI_NUM_EXT-1:0] extIn;
    logic [`ECI_NUM_CH-1:0]  chainIn;
    logic [`ECI_NUM_CH-1:0]  chainOut;
    logic [`ECI_NUM_CH-1:0]  chainOe;
    logic [`ECI_NUM_CH-1:0]  peerDrive;
    logic                    hostIrq;
    logic [`ECI_IDX_W-1:0]   hostVector;
    logic [31:0]             rdat;
    logic [1:0]              resp;
    logic [15:0]             seed;
    logic [1:0]              mm;
    int                      fails;
    int                      nChecks;

    eci_top eci_top_inst (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .axiReq     (axiReq),
        .axiRsp     (axiRsp),
        .extIn      (extIn),
        .chainIn    (chainIn),
        .chainOut   (chainOut),
        .chainOe    (chainOe),
        .hostIrq    (hostIrq),
        .hostVector (hostVector)
    );

    eci_peer eci_peer_inst (
        .chainOut  (chainOut),
        .chainOe   (chainOe),
        .peerDrive (peerDrive),
        .chainIn   (chainIn)
    );

    // 25 MHz board clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Repeatable pseudo-random source
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected winner: lowest set candidate
    function logic [4:0] low(input logic [19:0] m);
        low = 5'h1F;
        for (int i = 19; i >= 0; i--) if (m[i]) low = 5'(i);
    endfunction

    task close_out();
        if (fails == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Inputs never change faster than the least stable time
    task hold();
        repeat (`ECI_HOLD_CYC) @(posedge ref_clk);
    endtask

    // Write: address and data together, bready held until bvalid
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone  = 1'b0;
        @(posedge ref_clk);
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid  <= 1'b1;
        axiReq.awaddr  <= a;
        axiReq.wdata   <= d;
        axiReq.wstrb   <= 4'hF;
        axiReq.bready  <= 1'b1;
        // Each channel released at the edge that takes it
        do begin
            @(posedge ref_clk);
            if (!awDone && axiRsp.awready === 1'b1) begin
                awDone = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (!wDone && axiRsp.wready === 1'b1) begin
                wDone = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end while (!(awDone && wDone));
        do @(posedge ref_clk); while (axiRsp.bvalid !== 1'b1);
        resp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr  <= a;
        axiReq.rready  <= 1'b1;
        do @(posedge ref_clk); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        do @(posedge ref_clk); while (axiRsp.rvalid !== 1'b1);
        rdat = axiRsp.rdata;
        resp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        `CHK(n, e, rdat)
    endtask

    // Let the line settle, then look at the host side
    task irq(input logic e, input logic [4:0] v);
        hold();
        `CHK("hostIrq", e, hostIrq)
        if (e) `CHK("hostVector", v, hostVector)
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        close_out();
    end

    initial begin
        nrst      = 1'b0;
        axiReq    = '0;
        extIn     = 12'hFFD;
        peerDrive = 8'h00;
        seed      = 16'h0022;
        fails     = 0;
        nChecks   = 0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        hold();
        // Power-up state, unmapped place has no effect
        wr(8'h2C, 32'hFFFF_FFFF);
        `CHK("bresp", `ECI_RESP_SLVERR, resp)
        rdc(`ECI_OFF_EXT_ARM, 32'h0000_0000, "extArm");
        rdc(`ECI_OFF_EXT_EN, 32'h0000_0000, "extEn");
        rdc(`ECI_OFF_CH_ARM, 32'h0000_0000, "chArm");
        rdc(`ECI_OFF_CH_EN, 32'h0000_0000, "chEn");
        rdc(`ECI_OFF_EXT_MODE, 32'h0055_5555, "mode");
        rdc(`ECI_OFF_ROUTE, 32'hFFFF_FFFF, "route");
        rdc(`ECI_OFF_VECTOR, 32'h0000_0000, "vector");
        `CHK("chainOe", 8'h00, chainOe)
        // Random arm patterns: twelve external, eight chained
        repeat (4) begin
            seed = lfsr(seed);
            wr(`ECI_OFF_EXT_ARM, {16'h0000, seed});
            rdc(`ECI_OFF_EXT_ARM, {20'h0_0000, seed[11:0]}, "armRnd");
            wr(`ECI_OFF_CH_ARM, {16'h0000, ~seed});
            rdc(`ECI_OFF_CH_ARM, {24'h00_0000, ~seed[7:0]}, "chArmRnd");
        end
        wr(`ECI_OFF_EXT_ARM, 32'h0000_0000);
        wr(`ECI_OFF_CH_ARM, 32'h0000_0000);
        // Disarmed lines give nothing
        extIn[3] <= 1'b0;
        irq(1'b0, 5'h00);
        extIn[3] <= 1'b1;
        // Armed but disabled: held, delivered on enable
        wr(`ECI_OFF_EXT_ARM, 32'h0000_0020);
        extIn[6:5] <= 2'b00;
        irq(1'b0, 5'h00);
        rdc(`ECI_OFF_EXT_REQ, 32'h0000_0020, "extReq");
        extIn[6:5] <= 2'b11;
        wr(`ECI_OFF_EXT_EN, 32'h0000_0020);
        irq(1'b1, 5'h05);
        rdc(`ECI_OFF_VECTOR, 32'h0000_0025, "vecReg");
        wr(`ECI_OFF_EXT_PEND, 32'h0000_0020);
        // Two software requests at once: lowest first, one at a time
        wr(`ECI_OFF_EXT_ARM, 32'h0000_0084);
        wr(`ECI_OFF_EXT_EN, 32'h0000_0084);
        wr(`ECI_OFF_EXT_REQ, 32'h0000_0084);
        irq(1'b1, low(20'h0_0084));
        `CHK("chainOe", 8'h00, chainOe)
        irq(1'b1, low(20'h0_0084));
        wr(`ECI_OFF_EXT_PEND, 32'h0000_0004);
        irq(1'b1, low(20'h0_0080));
        wr(`ECI_OFF_EXT_PEND, 32'h0000_0080);
        irq(1'b0, 5'h00);
        // Disarm drops a held request and ignores new ones
        wr(`ECI_OFF_EXT_ARM, 32'h0000_0200);
        wr(`ECI_OFF_EXT_EN, 32'h0000_0000);
        wr(`ECI_OFF_EXT_REQ, 32'h0000_0200);
        rdc(`ECI_OFF_EXT_REQ, 32'h0000_0200, "reqSet");
        wr(`ECI_OFF_EXT_ARM, 32'h0000_0000);
        rdc(`ECI_OFF_EXT_REQ, 32'h0000_0000, "reqDrop");
        wr(`ECI_OFF_EXT_REQ, 32'h0000_0200);
        rdc(`ECI_OFF_EXT_REQ, 32'h0000_0000, "reqIgn");
        // Every mode on line 1: levels redeliver, edges do not
        for (int m = 0; m < 4; m++) begin
            mm = 2'(m);
            wr(`ECI_OFF_EXT_MODE, 32'h0055_5551 | (32'(mm) << 2));
            extIn[1] <= mm[0];
            hold();
            wr(`ECI_OFF_EXT_ARM, 32'h0000_0002);
            wr(`ECI_OFF_EXT_EN, 32'h0000_0002);
            extIn[1] <= ~mm[0];
            irq(1'b1, 5'h01);
            wr(`ECI_OFF_EXT_PEND, 32'h0000_0002);
            irq(mm[1], 5'h01);
            extIn[1] <= mm[0];
            wr(`ECI_OFF_EXT_ARM, 32'h0000_0000);
            wr(`ECI_OFF_EXT_PEND, 32'h0000_0002);
            irq(1'b0, 5'h00);
        end
        // Routed input: raw line reaches chain 0, chain starts disarmed
        wr(`ECI_OFF_ROUTE, 32'hFFFF_FFF4);
        wr(`ECI_OFF_EXT_ARM, 32'h0000_0010);
        wr(`ECI_OFF_EXT_EN, 32'h0000_0010);
        hold();
        `CHK("chainOe", 8'h01, chainOe)
        `CHK("chainOut", 1'b1, chainOut[0])
        extIn[4] <= 1'b0;
        irq(1'b1, 5'h04);
        `CHK("chainOut", 1'b0, chainOut[0])
        extIn[4] <= 1'b1;
        wr(`ECI_OFF_EXT_PEND, 32'h0000_0010);
        irq(1'b0, 5'h00);
        // Software request on the routed input stays local
        wr(`ECI_OFF_EXT_REQ, 32'h0000_0010);
        irq(1'b1, 5'h04);
        `CHK("chainOut", 1'b1, chainOut[0])
        wr(`ECI_OFF_EXT_PEND, 32'h0000_0010);
        // Local line disarmed, chain armed: only the chained vector
        wr(`ECI_OFF_EXT_ARM, 32'h0000_0000);
        wr(`ECI_OFF_CH_ARM, 32'h0000_0005);
        wr(`ECI_OFF_CH_EN, 32'h0000_0005);
        extIn[4] <= 1'b0;
        hold();
        extIn[4] <= 1'b1;
        irq(1'b1, 5'(`ECI_NUM_EXT));
        `CHK("chainIn", 1'b1, chainIn[0])
        wr(`ECI_OFF_CH_PEND, 32'h0000_0001);
        // Peer board raises chained line 2
        peerDrive <= 8'h04;
        irq(1'b1, 5'(`ECI_NUM_EXT + 2));
        wr(`ECI_OFF_CH_PEND, 32'h0000_0004);
        peerDrive <= 8'h00;
        // Software request on a chained line: local only
        wr(`ECI_OFF_CH_REQ, 32'h0000_0004);
        irq(1'b1, 5'(`ECI_NUM_EXT + 2));
        `CHK("chainOe", 8'h01, chainOe)
        wr(`ECI_OFF_CH_PEND, 32'h0000_0004);
        irq(1'b0, 5'h00);
        close_out();
    end
endmodule
